//--- design/mcb_bridge.v
// Modbus RTU serial frames to and from segmented CAN / CAN FD byte streams.
// Assumes a CAN controller that moves messages as header-plus-payload byte streams.
// What this block does
// - Convert serial frame only after full valid reception.
// - Address byte goes into lowest identifier byte.
// - Upper identifier bytes are all zero.
// - Same identifier for every segment of frame.
// - Frame flags constant across one frame's messages.
// - Serial CRC bytes never reach CAN payload.
// - Header first, content from second payload byte.
// - Classic CAN: seven content bytes per message.
// - CAN FD: 63 bytes, segment only beyond.
// - Content fitting one message: header 0x00.
// - Longer content: first 0x80-style, last 0xC2-style.
// - Header is framing, never forwarded as content.
// - Reassemble segments, add CRC16, send serially.
// - Discard whole group breaking segmentation rules.
// - Header bit 7: standalone 0, segmented 1.
// - Bits 6-5: first 0, middle 1, last 2.
// - Low five bits count segments 0 to 31.
// - Serial: start, eight data, stop, no parity.
`timescale 1ns/1ps
`include "mcb_map.vh"
module mcb_bridge #(
  parameter BIT_CYC = `MCB_BIT_CYC,
  parameter GAP_CYC = `MCB_GAP_CYC,
  parameter FIFO_DEPTH = 32,
  parameter FIFO_AW = 5,
  parameter FRAME_MAX = 256,
  parameter FRAME_AW = 8
) (
  // Clock and reset.
  input wire clk,
  input wire sys_rst,
  // Serial pins.
  input wire ser_rx,
  output wire ser_tx,
  // Mode and frame flags for outgoing CAN messages.
  input wire fd_mode,
  input wire [7:0] frame_flags,
  // Outgoing message stream; start marks the header byte.
  output reg ctx_start,
  output reg [31:0] ctx_id,
  output reg [7:0] ctx_flags,
  output reg [6:0] ctx_len,
  output reg ctx_valid,
  output reg [7:0] ctx_data,
  output reg ctx_last,
  input wire ctx_ready,
  // Incoming message stream: header first, last on the final byte.
  input wire crx_valid,
  input wire [7:0] crx_data,
  input wire crx_last,
  input wire [7:0] crx_addr,
  output wire crx_ready,
  // Pulses on frames dropped.
  output reg ser_drop,
  output reg can_drop
);
  // One CRC16 step over a byte.
  function [15:0] crc_byte;
    input [15:0] crc;
    input [7:0] data;
    integer i;
    reg [15:0] c;
    begin
      c = crc ^ {8'h00, data};
      for (i = 0; i < 8; i = i + 1) begin
        c = c[0] ? ((c >> 1) ^ `MCB_CRC_POLY) : (c >> 1);
      end
      crc_byte = c;
    end
  endfunction
  // Character transceiver wiring.
  wire rx_stb;
  wire [7:0] rx_byte;
  wire rx_err;
  wire gap_stb;
  wire tx_ready;
  wire fifo_out_valid;
  wire [7:0] fifo_out_data;
  reg tx_pop;
  mcb_uart #(.BIT_CYC(BIT_CYC), .GAP_CYC(GAP_CYC)) u_uart (
    .clk(clk), .sys_rst(sys_rst), .ser_rx(ser_rx), .ser_tx(ser_tx),
    .rx_stb(rx_stb), .rx_byte(rx_byte), .rx_err(rx_err), .gap_stb(gap_stb),
    .tx_valid(fifo_out_valid), .tx_ready(tx_ready), .tx_byte(fifo_out_data)
  );
  // Serial receive frame store.
  reg [7:0] sbuf [0:FRAME_MAX-1];
  reg [FRAME_AW:0] slen_reg;
  reg [15:0] scrc_reg;
  reg sbad_reg;
  // Outgoing conversion state.
  localparam TS_IDLE = 2'h0;
  localparam TS_HDR = 2'h1;
  localparam TS_DATA = 2'h2;
  reg [1:0] ts_reg;
  reg [FRAME_AW:0] tpos_reg;
  reg [FRAME_AW:0] tend_reg;
  reg [6:0] tcnt_reg;
  reg [4:0] tseg_reg;
  reg tsegd_reg;
  wire [6:0] tmax;
  wire [FRAME_AW:0] trem;
  wire [6:0] tchunk;
  assign tmax = fd_mode ? `MCB_MAX_FD : `MCB_MAX_CLASSIC;
  assign trem = tend_reg - tpos_reg;
  assign tchunk = (trem > {{(FRAME_AW-6){1'b0}}, tmax}) ? tmax : trem[6:0];
  // Serial receive: a good frame's running CRC ends at zero.
  always @(posedge clk) begin
    if (rx_stb && ts_reg == TS_IDLE && slen_reg < FRAME_MAX) begin
      sbuf[slen_reg[FRAME_AW-1:0]] <= rx_byte;
    end
  end
  always @(posedge clk) begin
    if (sys_rst) begin
      slen_reg <= {(FRAME_AW+1){1'b0}};
      scrc_reg <= `MCB_CRC_SEED;
      sbad_reg <= 1'b0;
      ts_reg <= TS_IDLE;
      ctx_start <= 1'b0;
      ctx_id <= 32'h0;
      ctx_flags <= 8'h0;
      ctx_len <= 7'h0;
      ctx_valid <= 1'b0;
      ctx_data <= 8'h0;
      ctx_last <= 1'b0;
      ser_drop <= 1'b0;
    end else begin
      ctx_start <= 1'b0;
      ser_drop <= 1'b0;
      // Characters during conversion spoil the frame.
      if (rx_stb) begin
        if (ts_reg != TS_IDLE || slen_reg >= FRAME_MAX || rx_err) begin
          sbad_reg <= 1'b1;
        end else begin
          slen_reg <= slen_reg + 1'b1;
          scrc_reg <= crc_byte(scrc_reg, rx_byte);
        end
      end
      case (ts_reg)
        TS_IDLE: begin
          if (gap_stb) begin
            slen_reg <= {(FRAME_AW+1){1'b0}};
            scrc_reg <= `MCB_CRC_SEED;
            sbad_reg <= 1'b0;
            if (!sbad_reg && scrc_reg == 16'h0000 && slen_reg >= `MCB_MIN_FRAME) begin
              ts_reg <= TS_HDR;
              tpos_reg <= {{FRAME_AW{1'b0}}, 1'b1};
              tend_reg <= slen_reg - 2'd2;
              tseg_reg <= 5'h0;
              tsegd_reg <= ((slen_reg - 2'd3) > {{(FRAME_AW-6){1'b0}}, tmax});
              ctx_id <= {24'h000000, sbuf[0]};
              ctx_flags <= frame_flags;
            end else begin
              ser_drop <= 1'b1;
            end
          end
        end
        TS_HDR: begin
          // Present the header byte once the previous message has drained.
          if (!ctx_valid || ctx_ready) begin
            ctx_start <= 1'b1;
            ctx_len <= tchunk + 7'h1;
            ctx_valid <= 1'b1;
            ctx_last <= 1'b0;
            tcnt_reg <= tchunk;
            if (!tsegd_reg) begin
              ctx_data <= `MCB_HDR_SINGLE;
            end else begin
              ctx_data <= {1'b1, (tseg_reg == 5'h0) ? `MCB_SEG_FIRST :
                (trem <= {{(FRAME_AW-6){1'b0}}, tmax}) ? `MCB_SEG_LAST : `MCB_SEG_MIDDLE, tseg_reg};
            end
            ts_reg <= TS_DATA;
          end
        end
        TS_DATA: begin
          // Content bytes follow the header, function code first.
          if (ctx_ready) begin
            if (tcnt_reg == 7'h0) begin
              ctx_valid <= 1'b0;
              ctx_last <= 1'b0;
              tseg_reg <= tseg_reg + 5'h1;
              ts_reg <= (tpos_reg >= tend_reg) ? TS_IDLE : TS_HDR;
            end else begin
              ctx_data <= sbuf[tpos_reg[FRAME_AW-1:0]];
              ctx_last <= (tcnt_reg == 7'h1);
              tpos_reg <= tpos_reg + 1'b1;
              tcnt_reg <= tcnt_reg - 7'h1;
            end
          end
        end
        default: begin
          ts_reg <= TS_IDLE;
        end
      endcase
    end
  end
  // CAN receive: check segments, gather content, then send.
  localparam RS_IDLE = 2'h0;
  localparam RS_BODY = 2'h1;
  localparam RS_SEND = 2'h2;
  localparam RS_CRC = 2'h3;
  reg [1:0] rs_reg;
  reg [7:0] rbuf [0:FRAME_MAX-1];
  reg [FRAME_AW:0] rlen_reg;
  reg [FRAME_AW:0] rsent_reg;
  reg [4:0] rseg_reg;
  reg rgrp_reg;
  reg rdone_reg;
  reg rbad_reg;
  // Set while the rest of a refused message is skipped.
  reg rskip_reg;
  reg [15:0] rcrc_reg;
  reg rcrc_hi_reg;
  reg [7:0] fifo_in_data;
  reg fifo_in_valid;
  wire fifo_in_ready;
  wire hdr_ok;
  wire [1:0] htype;
  assign htype = crx_data[6:5];
  // Header legality against the running group.
  assign hdr_ok = !crx_data[`MCB_HDR_SEG_BIT] ? (crx_data == `MCB_HDR_SINGLE && !rgrp_reg) :
    (crx_data[4:0] == rseg_reg) && (rgrp_reg ? (htype == `MCB_SEG_MIDDLE || htype == `MCB_SEG_LAST) :
    (htype == `MCB_SEG_FIRST && crx_data[4:0] == 5'h0));
  assign crx_ready = (rs_reg == RS_IDLE) || (rs_reg == RS_BODY);
  always @(posedge clk) begin
    if (rs_reg == RS_BODY && crx_valid && rlen_reg < FRAME_MAX) begin
      rbuf[rlen_reg[FRAME_AW-1:0]] <= crx_data;
    end
  end
  always @(posedge clk) begin
    if (sys_rst) begin
      rs_reg <= RS_IDLE;
      rlen_reg <= {(FRAME_AW+1){1'b0}};
      rseg_reg <= 5'h0;
      rgrp_reg <= 1'b0;
      rbad_reg <= 1'b0;
      rskip_reg <= 1'b0;
      can_drop <= 1'b0;
    end else begin
      can_drop <= 1'b0;
      case (rs_reg)
        RS_IDLE: begin
          // Header byte: framing only, not stored.
          if (crx_valid && rskip_reg) begin
            // Body of a refused message goes with its header, one drop per message.
            rskip_reg <= !crx_last;
          end else if (crx_valid) begin
            if (!hdr_ok || crx_last) begin
              can_drop <= rgrp_reg || !hdr_ok;
              rskip_reg <= !crx_last;
              rgrp_reg <= 1'b0;
              rseg_reg <= 5'h0;
              rlen_reg <= {(FRAME_AW+1){1'b0}};
              rbad_reg <= 1'b0;
            end else begin
              rs_reg <= RS_BODY;
              rgrp_reg <= crx_data[`MCB_HDR_SEG_BIT];
              rdone_reg <= !crx_data[`MCB_HDR_SEG_BIT] || htype == `MCB_SEG_LAST;
              rseg_reg <= rseg_reg + 5'h1;
              // A later header adds no content, so the length stays.
              if (!rgrp_reg) begin
                rlen_reg <= {{FRAME_AW{1'b0}}, 1'b1};
                rbad_reg <= 1'b0;
              end
            end
          end
          // Address byte leads the rebuilt serial frame.
          if (!rgrp_reg) begin
            rcrc_reg <= crc_byte(`MCB_CRC_SEED, crx_addr);
          end
        end
        RS_BODY: begin
          // Content bytes; overflow poisons the group.
          if (crx_valid) begin
            if (rlen_reg >= FRAME_MAX - 2) begin
              rbad_reg <= 1'b1;
            end else begin
              rlen_reg <= rlen_reg + 1'b1;
              rcrc_reg <= crc_byte(rcrc_reg, crx_data);
            end
            if (crx_last) begin
              if (rdone_reg) begin
                rgrp_reg <= 1'b0;
                rseg_reg <= 5'h0;
                if (rbad_reg || rlen_reg >= FRAME_MAX - 2) begin
                  can_drop <= 1'b1;
                  rs_reg <= RS_IDLE;
                end else begin
                  rs_reg <= RS_SEND;
                  rsent_reg <= {(FRAME_AW+1){1'b0}};
                end
              end else begin
                rs_reg <= RS_IDLE;
              end
            end
          end
        end
        RS_SEND: begin
          // Push the frame, then the CRC.
          if (fifo_in_ready) begin
            rsent_reg <= rsent_reg + 1'b1;
            if (rsent_reg + 1'b1 == rlen_reg) begin
              rs_reg <= RS_CRC;
              rcrc_hi_reg <= 1'b0;
            end
          end
        end
        RS_CRC: begin
          if (fifo_in_ready) begin
            rcrc_hi_reg <= 1'b1;
            if (rcrc_hi_reg) begin
              rs_reg <= RS_IDLE;
              rlen_reg <= {(FRAME_AW+1){1'b0}};
            end
          end
        end
        default: begin
          rs_reg <= RS_IDLE;
        end
      endcase
    end
  end
  // FIFO feed: address, content, CRC low then high.
  always @* begin
    fifo_in_valid = (rs_reg == RS_SEND) || (rs_reg == RS_CRC);
    fifo_in_data = 8'h00;
    tx_pop = fifo_out_valid && tx_ready;
    if (rs_reg == RS_SEND) begin
      fifo_in_data = (rsent_reg == {(FRAME_AW+1){1'b0}}) ? crx_addr : rbuf[rsent_reg[FRAME_AW-1:0]];
    end else if (rs_reg == RS_CRC) begin
      fifo_in_data = rcrc_hi_reg ? rcrc_reg[15:8] : rcrc_reg[7:0];
    end
  end
  mcb_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo (
    .clk(clk), .sys_rst(sys_rst),
    .in_valid(fifo_in_valid), .in_ready(fifo_in_ready), .in_data(fifo_in_data),
    .out_valid(fifo_out_valid), .out_ready(tx_pop), .out_data(fifo_out_data)
  );
endmodule // mcb_bridge

//--- design/mcb_map.vh
// Bridge constants: header fields, widths and timing counts.
// Assumes inclusion by the bridge modules; definitions only.
`ifndef MCB_MAP_VH
`define MCB_MAP_VH
// System clock frequency in Hz.
`define MCB_CLK_HZ 200000000
// Default serial bit rate in bits per second.
`define MCB_BAUD 115200
// Clock cycles per serial bit, rounded down.
`define MCB_BIT_CYC (`MCB_CLK_HZ / `MCB_BAUD)
// Bits in one serial character: start, eight data, stop.
`define MCB_CHAR_BITS 10
// End-of-frame silence in tenths of a character time.
`define MCB_GAP_TENTHS 35
// Silence count in cycles, rounded up.
`define MCB_GAP_CYC ((`MCB_BIT_CYC * `MCB_CHAR_BITS * `MCB_GAP_TENTHS + 9) / 10)
// Header bit that marks a segmented message.
`define MCB_HDR_SEG_BIT 7
// Segment type codes in header bits 6 to 5.
`define MCB_SEG_FIRST 2'h0
`define MCB_SEG_MIDDLE 2'h1
`define MCB_SEG_LAST 2'h2
// Header of a standalone message.
`define MCB_HDR_SINGLE 8'h00
// Content bytes per message in classic and FD mode.
`define MCB_MAX_CLASSIC 7'h07
`define MCB_MAX_FD 7'h3f
// Modbus CRC16 reflected polynomial and seed.
`define MCB_CRC_POLY 16'ha001
`define MCB_CRC_SEED 16'hffff
// Smallest valid serial frame: address, function code, two CRC bytes.
`define MCB_MIN_FRAME 4
`endif

//--- design/mcb_fifo.v
// Synchronous FIFO with valid/ready on both sides, parameterised width and depth.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module mcb_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  // Clock and reset.
  input wire clk,
  input wire sys_rst,
  // Filling side.
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // Draining side.
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  // Storage array.
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  // Pointers carry one extra wrap bit.
  reg [AW:0] wr_ptr_reg;
  reg [AW:0] rd_ptr_reg;
  wire full, empty;
  assign empty = (wr_ptr_reg == rd_ptr_reg);
  assign full = (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]) && (wr_ptr_reg[AW] != rd_ptr_reg[AW]);
  assign in_ready = ~full;
  assign out_valid = ~empty;
  assign out_data = mem[rd_ptr_reg[AW-1:0]];
  // Store a word when offered and not full.
  always @(posedge clk) begin
    if (in_valid && !full) begin
      mem[wr_ptr_reg[AW-1:0]] <= in_data;
    end
  end
  // Advance pointers on each accepted word.
  always @(posedge clk) begin
    if (sys_rst) begin
      wr_ptr_reg <= {(AW+1){1'b0}};
      rd_ptr_reg <= {(AW+1){1'b0}};
    end else begin
      if (in_valid && !full) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (out_ready && !empty) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end
endmodule // mcb_fifo

//--- design/mcb_uart.v
// Serial character transceiver: one start bit, eight data bits, one stop bit, no parity.
// Assumes an asynchronous receive pin, synchronised here; also reports line silence.
`timescale 1ns/1ps
`include "mcb_map.vh"
module mcb_uart #(
  parameter BIT_CYC = `MCB_BIT_CYC,
  parameter GAP_CYC = `MCB_GAP_CYC
) (
  // Clock and reset.
  input wire clk,
  input wire sys_rst,
  // Serial pins.
  input wire ser_rx,
  output reg ser_tx,
  // Received character, one-cycle pulse.
  output reg rx_stb,
  output reg [7:0] rx_byte,
  output reg rx_err,
  // One-cycle pulse after the end-of-frame silence.
  output reg gap_stb,
  // Transmit character handshake.
  input wire tx_valid,
  output wire tx_ready,
  input wire [7:0] tx_byte
);
  // Two-stage synchroniser for the receive pin.
  reg rx_s1_reg;
  reg rx_s2_reg;
  // Receiver state.
  reg rx_busy_reg;
  reg [31:0] rx_cnt_reg;
  reg [3:0] rx_bit_reg;
  reg [8:0] rx_sh_reg;
  reg [31:0] gap_cnt_reg;
  reg gap_arm_reg;
  // Transmitter state.
  reg tx_busy_reg;
  reg [31:0] tx_cnt_reg;
  reg [3:0] tx_bit_reg;
  reg [9:0] tx_sh_reg;
  assign tx_ready = ~tx_busy_reg;
  // Synchronise the receive pin.
  always @(posedge clk) begin
    if (sys_rst) begin
      rx_s1_reg <= 1'b1;
      rx_s2_reg <= 1'b1;
    end else begin
      rx_s1_reg <= ser_rx;
      rx_s2_reg <= rx_s1_reg;
    end
  end
  // Receive: sample mid-bit, check stop, then time the silence.
  always @(posedge clk) begin
    if (sys_rst) begin
      rx_busy_reg <= 1'b0;
      rx_stb <= 1'b0;
      rx_byte <= 8'h0;
      rx_err <= 1'b0;
      gap_cnt_reg <= 32'h0;
      gap_arm_reg <= 1'b0;
      gap_stb <= 1'b0;
    end else begin
      rx_stb <= 1'b0;
      gap_stb <= 1'b0;
      if (!rx_busy_reg) begin
        if (!rx_s2_reg) begin
          // Start bit seen; sample it again at half a bit.
          rx_busy_reg <= 1'b1;
          rx_cnt_reg <= BIT_CYC / 2;
          rx_bit_reg <= 4'h0;
          gap_cnt_reg <= 32'h0;
        end else if (gap_arm_reg) begin
          // Idle line after a character: count toward the frame gap.
          if (gap_cnt_reg >= GAP_CYC - 1) begin
            gap_stb <= 1'b1;
            gap_arm_reg <= 1'b0;
          end else begin
            gap_cnt_reg <= gap_cnt_reg + 32'h1;
          end
        end
      end else if (rx_cnt_reg != 32'h0) begin
        rx_cnt_reg <= rx_cnt_reg - 32'h1;
      end else begin
        rx_cnt_reg <= BIT_CYC - 1;
        rx_sh_reg <= {rx_s2_reg, rx_sh_reg[8:1]};
        rx_bit_reg <= rx_bit_reg + 4'h1;
        if (rx_bit_reg == 4'h0 && rx_s2_reg) begin
          // Glitch instead of a start bit.
          rx_busy_reg <= 1'b0;
        end else if (rx_bit_reg == 4'h9) begin
          // Stop bit sampled; character complete.
          rx_busy_reg <= 1'b0;
          rx_stb <= 1'b1;
          rx_byte <= rx_sh_reg[8:1];
          rx_err <= ~rx_s2_reg;
          gap_arm_reg <= 1'b1;
          gap_cnt_reg <= 32'h0;
        end
      end
    end
  end
  // Transmit: shift start, eight data bits LSB first, stop.
  always @(posedge clk) begin
    if (sys_rst) begin
      tx_busy_reg <= 1'b0;
      ser_tx <= 1'b1;
    end else if (!tx_busy_reg) begin
      ser_tx <= 1'b1;
      if (tx_valid) begin
        tx_busy_reg <= 1'b1;
        tx_sh_reg <= {1'b1, tx_byte, 1'b0};
        tx_cnt_reg <= BIT_CYC - 1;
        tx_bit_reg <= 4'h0;
        ser_tx <= 1'b0;
      end
    end else if (tx_cnt_reg != 32'h0) begin
      tx_cnt_reg <= tx_cnt_reg - 32'h1;
    end else if (tx_bit_reg == 4'h9) begin
      tx_busy_reg <= 1'b0;
      ser_tx <= 1'b1;
    end else begin
      tx_cnt_reg <= BIT_CYC - 1;
      tx_bit_reg <= tx_bit_reg + 4'h1;
      tx_sh_reg <= {1'b1, tx_sh_reg[9:1]};
      ser_tx <= tx_sh_reg[1];
    end
  end
endmodule // mcb_uart

//--- tb/mcb_bridge_assertions.sv
// Checker on the bridge ports: message framing and hold rules.
// Assumes it is bound onto mcb_bridge and sees only its ports.
`timescale 1ns/1ps
module mcb_bridge_assertions (
  // Clock, reset and mode.
  input wire clk,
  input wire sys_rst,
  input wire fd_mode,
  // Outgoing message stream.
  input wire ctx_start,
  input wire [31:0] ctx_id,
  input wire [7:0] ctx_flags,
  input wire [6:0] ctx_len,
  input wire ctx_valid,
  input wire [7:0] ctx_data,
  input wire ctx_last,
  input wire ctx_ready
);
  // Bytes taken in this message.
  reg [6:0] cnt_reg;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Restart at each header.
  always @(posedge clk) begin
    if (sys_rst)
      cnt_reg <= 7'h00;
    else if (ctx_valid && ctx_ready)
      cnt_reg <= (ctx_start ? 7'h00 : cnt_reg) + 7'h01;
    else if (ctx_start)
      cnt_reg <= 7'h00;
  end
  chk_id_upper_zero: assert property (
    ctx_valid |-> ctx_id[31:8] == 24'h0) else $error("Upper identifier bytes set.");
  chk_start_header: assert property (
    ctx_start |-> ctx_valid && ctx_len >= 7'h02) else $error("Start without header and content.");
  chk_single_header: assert property (
    ctx_start && !ctx_data[7] |-> ctx_data == 8'h00) else $error("Standalone header not zero.");
  chk_seg_type: assert property (
    ctx_start && ctx_data[7] |-> ctx_data[6:5] != 2'h3) else $error("Reserved segment type.");
  chk_len_classic: assert property (
    ctx_start && !fd_mode |-> ctx_len <= 7'h08) else $error("Classic message too long.");
  chk_len_fd: assert property (
    ctx_start && fd_mode |-> ctx_len <= 7'h40) else $error("FD message too long.");
  chk_hold_byte: assert property (
    ctx_valid && !ctx_ready |=> ctx_valid && $stable(ctx_data) && $stable(ctx_last))
    else $error("Byte changed before taken.");
  chk_frame_ids: assert property (
    ctx_valid && !(ctx_ready && ctx_last) |=> $stable(ctx_id) && $stable(ctx_flags))
    else $error("Identifier or flags changed in a message.");
  chk_byte_count: assert property (
    ctx_valid && ctx_ready && ctx_last |-> (ctx_start ? 7'h00 : cnt_reg) + 7'h01 == ctx_len)
    else $error("Byte count differs from length.");
endmodule // mcb_bridge_assertions
bind mcb_bridge mcb_bridge_assertions u_chk (.clk, .sys_rst, .fd_mode,
  .ctx_start, .ctx_id, .ctx_flags, .ctx_len, .ctx_valid, .ctx_data, .ctx_last, .ctx_ready);

//--- tb/mcb_can_node.sv
// CAN node model: sinks outgoing bytes, feeds incoming groups.
// Assumes the bench calls send_msg at a rising clock edge.
`timescale 1ns/1ps
module mcb_can_node (
  // Clock, reset and stall control.
  input wire clk,
  input wire sys_rst,
  input wire slow,
  // Outgoing stream from the bridge.
  input wire ctx_start,
  input wire [31:0] ctx_id,
  input wire [7:0] ctx_flags,
  input wire ctx_valid,
  input wire [7:0] ctx_data,
  input wire ctx_last,
  output logic ctx_ready,
  // Incoming stream toward the bridge.
  output logic crx_valid,
  output logic [7:0] crx_data,
  output logic crx_last,
  output logic [7:0] crx_addr,
  input wire crx_ready
);
  // Headers, identifiers, flags and rebuilt content seen so far.
  logic [7:0] hdr_q[$];
  logic [31:0] id_q[$];
  logic [7:0] flg_q[$];
  logic [7:0] body_q[$];
  // Next accepted byte is a header.
  logic first = 1'b1;
  initial begin
    ctx_ready = 1'b1;
    crx_valid = 1'b0;
    crx_data = 8'h00;
    crx_last = 1'b0;
    crx_addr = 8'h00;
  end
  // Split headers from content; slow halves the take rate.
  always @(posedge clk) begin
    ctx_ready <= slow ? ~ctx_ready : 1'b1;
    if (sys_rst)
      first <= 1'b1;
    else if (ctx_valid && ctx_ready) begin
      first <= ctx_last;
      if (first) begin
        hdr_q.push_back(ctx_data);
        id_q.push_back(ctx_id);
        flg_q.push_back(ctx_flags);
      end else
        body_q.push_back(ctx_data);
    end
  end
  // Send one message; ready is read while settled, before the taking edge.
  task send_msg(input logic [7:0] a, input logic [7:0] m[$]);
    crx_addr <= a;
    foreach (m[i]) begin
      crx_valid <= 1'b1;
      crx_data <= m[i];
      crx_last <= (i == m.size() - 1);
      @(negedge clk);
      while (crx_ready !== 1'b1)
        @(negedge clk);
      @(posedge clk);
    end
    // Released data shows the inverse of the last byte.
    crx_valid <= 1'b0;
    crx_data <= ~crx_data;
    crx_last <= 1'b0;
    @(posedge clk);
  endtask
endmodule // mcb_can_node

//--- tb/mcb_bridge_tb_top.sv
// Bridge testbench: frames both ways against the CAN node model.
// Assumes a short serial bit time so frames fit a short run.
`timescale 1ns/1ps
module mcb_bridge_tb_top;
  localparam int BIT = 16;
  localparam int GAP = (BIT * 10 * 35 + 9) / 10;
  // Stimulus and observed signals.
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic ser_rx = 1'b1;
  logic fd_mode = 1'b0;
  logic [7:0] frame_flags = 8'h00;
  logic slow = 1'b0;
  wire ser_tx, ctx_start, ctx_valid, ctx_last, ctx_ready, crx_valid, crx_last, crx_ready, ser_drop, can_drop;
  wire [31:0] ctx_id;
  wire [7:0] ctx_flags, ctx_data, crx_data, crx_addr;
  wire [6:0] ctx_len;
  int err_count = 0;
  int total_checks = 0;
  int ser_drops = 0;
  int can_drops = 0;
  logic [7:0] frm[$];
  logic [7:0] exp[$];
  always #2.5 clk = ~clk;
  mcb_bridge #(.BIT_CYC(BIT), .GAP_CYC(GAP)) dut (.clk, .sys_rst, .ser_rx, .ser_tx, .fd_mode, .frame_flags,
    .ctx_start, .ctx_id, .ctx_flags, .ctx_len, .ctx_valid, .ctx_data, .ctx_last, .ctx_ready,
    .crx_valid, .crx_data, .crx_last, .crx_addr, .crx_ready, .ser_drop, .can_drop);
  mcb_can_node u_node (.clk, .sys_rst, .slow, .ctx_start, .ctx_id, .ctx_flags, .ctx_valid, .ctx_data,
    .ctx_last, .ctx_ready, .crx_valid, .crx_data, .crx_last, .crx_addr, .crx_ready);
  // Count drop pulses as they happen.
  always @(posedge clk) begin
    ser_drops <= ser_drops + (ser_drop === 1'b1);
    can_drops <= can_drops + (can_drop === 1'b1);
  end
  task check(input string what, input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
    end
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Reflected CRC16 with all-ones seed.
  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (q[i]) begin
      c ^= {8'h00, q[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    end
    return c;
  endfunction
  // Drive one 8N1 character, LSB first.
  task ser_put(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      ser_rx <= f[i];
      repeat (BIT) @(posedge clk);
    end
  endtask
  // Send frm plus CRC, low byte first; bad inverts the CRC.
  task ser_frame(input logic bad);
    logic [15:0] c;
    c = crc16(frm) ^ {16{bad}};
    foreach (frm[i]) ser_put(frm[i]);
    ser_put(c[7:0]);
    ser_put(c[15:8]);
  endtask
  // Sample one serial character mid-bit.
  task ser_get(output logic [7:0] b);
    int n;
    n = 0;
    while (ser_tx !== 1'b0 && n < 4 * GAP) begin
      @(posedge clk);
      n++;
    end
    repeat (BIT / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge clk);
      b[i] = ser_tx;
    end
    repeat (BIT) @(posedge clk);
    check("stop bit", ser_tx, 1'b1);
  endtask
  // Wait for content, then compare every message.
  task check_out(input logic [7:0] a, input int nm);
    int t;
    t = 0;
    while (u_node.body_q.size() < exp.size() && t < 20000) begin
      @(posedge clk);
      t++;
    end
    repeat (GAP) @(posedge clk);
    check("message count", u_node.hdr_q.size(), nm);
    check("content count", u_node.body_q.size(), exp.size());
    foreach (exp[i]) check("content", u_node.body_q[i], exp[i]);
    foreach (u_node.hdr_q[i]) begin
      check("identifier", u_node.id_q[i], {24'h0, a});
      check("flags", u_node.flg_q[i], frame_flags);
      if (nm == 1)
        check("single header", u_node.hdr_q[i], 8'h00);
      else begin
        check("segment type", u_node.hdr_q[i][7:5], i == 0 ? 3'h4 : (i == nm - 1 ? 3'h6 : 3'h5));
        if (i > 0)
          check("segment count", u_node.hdr_q[i][4:0], u_node.hdr_q[i - 1][4:0] + 5'h01);
      end
    end
    u_node.hdr_q.delete();
    u_node.id_q.delete();
    u_node.flg_q.delete();
    u_node.body_q.delete();
  endtask
  task t_single;
    frm = '{8'h08, 8'h11, 8'h00, 8'h01, 8'h00, 8'h02};
    exp = frm[1:$];
    frame_flags <= 8'h16;
    ser_frame(1'b0);
    check_out(8'h08, 1);
  endtask
  task t_segment;
    frm = '{8'h08, 8'h11, 8'h00, 8'h01, 8'h00, 8'h02, 8'h04, 8'h00, 8'h0a, 8'h01, 8'h02};
    exp = frm[1:$];
    slow <= 1'b1;
    frame_flags <= 8'h88;
    ser_frame(1'b0);
    check_out(8'h08, 2);
    slow <= 1'b0;
  endtask
  // FD boundary: 63 content bytes fit one message, 64 need two.
  task t_fd;
    fd_mode <= 1'b1;
    frame_flags <= 8'h30;
    for (int n = 63; n <= 64; n++) begin
      frm = '{8'h21};
      for (int i = 0; i < n; i++) frm.push_back(8'h40 + i[7:0]);
      exp = frm[1:$];
      ser_frame(1'b0);
      check_out(8'h21, n - 62);
    end
    fd_mode <= 1'b0;
  endtask
  task t_bad_crc;
    int d;
    d = ser_drops;
    frm = '{8'h08, 8'h03, 8'h00, 8'h01};
    exp = {};
    ser_frame(1'b1);
    check_out(8'h08, 0);
    check("serial drops", ser_drops, d + 1);
  endtask
  task t_can_ser;
    logic [7:0] b;
    exp = '{8'h08, 8'h11, 8'h00, 8'h01, 8'h00, 8'h02, 8'h04, 8'h00, 8'h0a, 8'h01, 8'h02};
    u_node.send_msg(8'h08, '{8'h80, 8'h11, 8'h00, 8'h01, 8'h00, 8'h02, 8'h04, 8'h00});
    u_node.send_msg(8'h08, '{8'hc1, 8'h0a, 8'h01, 8'h02});
    exp.push_back(8'hed);
    exp.push_back(8'h69);
    foreach (exp[i]) begin
      ser_get(b);
      check("serial byte", b, exp[i]);
    end
  endtask
  // A last segment with no first is discarded.
  task t_bad_group;
    int d;
    int lows;
    d = can_drops;
    lows = 0;
    u_node.send_msg(8'h08, '{8'hc1, 8'h0a});
    repeat (4 * GAP) begin
      @(posedge clk);
      lows += (ser_tx !== 1'b1);
    end
    check("group drops", can_drops, d + 1);
    check("serial idle", lows, 0);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    t_single();
    t_segment();
    t_fd();
    t_bad_crc();
    t_can_ser();
    t_bad_group();
    close_out();
  end
  // Watchdog well past the run length.
  initial begin
    repeat (90000) @(posedge clk);
    err_count++;
    close_out();
  end
endmodule // mcb_bridge_tb_top
